/* File: design/tpsc_top.sv */
// What this block does
// - Bits 7-4 pick the fixed pattern; reset value one; 0 and 15 reserved.
// - Codes six to thirteen give horizontal or vertical ramps spread evenly.
// - Code fourteen gives the custom colour or its inverse.
// - Auto-scroll makes the fixed-pattern selector ignored.
// - Control bit 3 selects the compliance pattern over the selector.
// - Control bit 2 enables colour bars white to black in eight steps.
// - Control bit 1 swaps yellow and blue in the left half of the four bands.
// - Control bit 0 enables the generator; off after reset.
// - A configuration bit chooses normal or inverted colour of each pair.
// - Auto-scroll steps to the next pattern after a programmed frame count.
//
// Purpose: Selects and drives the internal video test pattern per pixel.
// Assumes: i_de and i_frame_start come from timing logic on i_clk.
// Notes: Source changes take effect two cycles after the register write; selector code and colour changes take one.
`timescale 1ns/1ns
`default_nettype none
module tpsc_top #(
  parameter int unsigned H_ACTIVE = 1920,
  parameter int unsigned V_ACTIVE = 1080
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input wire tpsc_pkg::tpsc_bus_req_t i_bus,
  output logic [7:0] o_rdata,
  // Video timing
  input wire logic i_de,
  input wire logic i_frame_start,
  // Pixel output
  output tpsc_pkg::tpsc_rgb_t o_pix,
  output logic o_pix_valid,
  output logic o_gen_active,
  output logic o_loop_pwdn
);

  localparam int unsigned FW = $clog2((H_ACTIVE > V_ACTIVE ?
                                       H_ACTIVE : V_ACTIVE) + 1) + 1;
  localparam logic [FW-1:0] H_TOT = FW'(H_ACTIVE);
  localparam logic [FW-1:0] V_TOT = FW'(V_ACTIVE);
  localparam logic [FW-1:0] LVL_ADD = FW'(tpsc_pkg::LEVELS);
  localparam logic [FW-1:0] BAR_ADD = FW'(tpsc_pkg::BARS);
  localparam logic [FW-1:0] H_HALF = FW'(H_ACTIVE / 2);
  localparam logic [FW-1:0] V_HALF = FW'(V_ACTIVE / 2);
  if (H_ACTIVE < tpsc_pkg::LEVELS || V_ACTIVE < tpsc_pkg::LEVELS) begin
    $error("Active region must hold at least one pixel per level.");
  end
  // Spreads steps evenly: returns carry and the new remainder.
  function automatic logic [FW:0] frac_step(input logic [FW-1:0] frac,
                                            input logic [FW-1:0] add,
                                            input logic [FW-1:0] total);
    logic [FW:0] sum;
    sum = {1'b0, frac} + {1'b0, add};
    frac_step = (sum >= {1'b0, total}) ? {1'b1, FW'(sum - {1'b0, total})} :
                                         {1'b0, sum[FW-1:0]};
  endfunction : frac_step
  logic [7:0] ctl_ff, cfg_ff, loop_ff, aux_ff, ftime_ff;
  tpsc_pkg::tpsc_rgb_t custom_ff;
  logic [7:0] rdata_ff;
  logic [3:0] sel, eff_code, scroll_code_ff;
  logic [7:0] frame_cnt_ff;
  tpsc_pkg::tpsc_src_t src_ff, nxt_src;
  logic [FW-1:0] hfrac_ff, hbfrac_ff, vfrac_ff, hx_ff, vy_ff;
  logic [7:0] hlevel_ff, vlevel_ff;
  logic [2:0] hbar_ff;
  logic de_d_ff;
  logic [FW:0] h_lvl_nx, h_bar_nx, v_lvl_nx;
  tpsc_pkg::tpsc_rgb_t fixed_rgb, bar_rgb, band_rgb, compl_rgb, nxt_pix;
  tpsc_pkg::tpsc_rgb_t pix_ff;
  logic valid_ff;

  assign sel = ctl_ff[tpsc_pkg::SEL_MSB:tpsc_pkg::SEL_LSB];

  // Register writes.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctl_ff <= tpsc_pkg::CONTROL_RST;
      cfg_ff <= tpsc_pkg::ZERO_RST;
      loop_ff <= tpsc_pkg::ZERO_RST;
      aux_ff <= tpsc_pkg::ZERO_RST;
      ftime_ff <= tpsc_pkg::FRAME_TIME_RST;
      custom_ff <= tpsc_pkg::RGB_BLACK;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        tpsc_pkg::ADDR_CONTROL: ctl_ff <= i_bus.wdata;
        tpsc_pkg::ADDR_CONFIG: cfg_ff <= i_bus.wdata & 8'h03;
        tpsc_pkg::ADDR_LOOP_CTL: loop_ff <= i_bus.wdata & 8'h01;
        tpsc_pkg::ADDR_AUX: aux_ff <= i_bus.wdata & 8'h01;
        tpsc_pkg::ADDR_FRAME_TIME: ftime_ff <= i_bus.wdata;
        tpsc_pkg::ADDR_CUST_R: custom_ff.r <= i_bus.wdata;
        tpsc_pkg::ADDR_CUST_G: custom_ff.g <= i_bus.wdata;
        tpsc_pkg::ADDR_CUST_B: custom_ff.b <= i_bus.wdata;
        default: ;
      endcase
    end
  end
  // Register reads, data one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_ff <= 8'h00;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        tpsc_pkg::ADDR_CONTROL: rdata_ff <= ctl_ff;
        tpsc_pkg::ADDR_CONFIG: rdata_ff <= cfg_ff;
        tpsc_pkg::ADDR_LOOP_CTL: rdata_ff <= loop_ff;
        tpsc_pkg::ADDR_AUX: rdata_ff <= aux_ff;
        tpsc_pkg::ADDR_FRAME_TIME: rdata_ff <= ftime_ff;
        tpsc_pkg::ADDR_CUST_R: rdata_ff <= custom_ff.r;
        tpsc_pkg::ADDR_CUST_G: rdata_ff <= custom_ff.g;
        tpsc_pkg::ADDR_CUST_B: rdata_ff <= custom_ff.b;
        tpsc_pkg::ADDR_STATUS:
          rdata_ff <= {3'h0, src_ff == tpsc_pkg::SRC_FIXED, eff_code};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  // Source selection in fixed priority order.
  always_comb begin
    if (!ctl_ff[tpsc_pkg::EN_BIT]) begin
      nxt_src = tpsc_pkg::SRC_OFF;
    end else if (ctl_ff[tpsc_pkg::COMPL_BIT]) begin
      nxt_src = tpsc_pkg::SRC_COMPL;
    end else if (ctl_ff[tpsc_pkg::BARS_BIT]) begin
      nxt_src = tpsc_pkg::SRC_BARS;
    end else if (aux_ff[tpsc_pkg::FOUR_BAND_BIT]) begin
      nxt_src = tpsc_pkg::SRC_BAND;
    end else begin
      nxt_src = tpsc_pkg::SRC_FIXED;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_ff <= tpsc_pkg::SRC_OFF;
    end else begin
      src_ff <= nxt_src;
    end
  end
  // Auto-scroll walks codes one to fourteen; a frame time of zero acts as one.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scroll_code_ff <= tpsc_pkg::SEL_FIRST;
      frame_cnt_ff <= 8'h00;
    end else if (i_frame_start && cfg_ff[tpsc_pkg::ASCRL_BIT] &&
                 src_ff == tpsc_pkg::SRC_FIXED) begin
      if (frame_cnt_ff + 8'h01 >= ftime_ff) begin
        frame_cnt_ff <= 8'h00;
        scroll_code_ff <= (scroll_code_ff >= tpsc_pkg::SEL_LAST) ?
                          tpsc_pkg::SEL_FIRST : scroll_code_ff + 4'h1;
      end else begin
        frame_cnt_ff <= frame_cnt_ff + 8'h01;
      end
    end
  end

  assign eff_code = cfg_ff[tpsc_pkg::ASCRL_BIT] ? scroll_code_ff : sel;
  // Horizontal and vertical position, ramp levels and bar index.
  assign h_lvl_nx = frac_step(hfrac_ff, LVL_ADD, H_TOT);
  assign h_bar_nx = frac_step(hbfrac_ff, BAR_ADD, H_TOT);
  assign v_lvl_nx = frac_step(vfrac_ff, LVL_ADD, V_TOT);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hfrac_ff <= '0;
      hbfrac_ff <= '0;
      hx_ff <= '0;
      hlevel_ff <= 8'h00;
      hbar_ff <= 3'h0;
    end else begin
      hfrac_ff <= i_de ? h_lvl_nx[FW-1:0] : '0;
      hbfrac_ff <= i_de ? h_bar_nx[FW-1:0] : '0;
      hx_ff <= i_de ? hx_ff + FW'(1) : '0;
      hlevel_ff <= i_de ? hlevel_ff + {7'h00, h_lvl_nx[FW]} : 8'h00;
      hbar_ff <= i_de ? hbar_ff + {2'h0, h_bar_nx[FW]} : 3'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      de_d_ff <= 1'b0;
      vfrac_ff <= '0;
      vy_ff <= '0;
      vlevel_ff <= 8'h00;
    end else begin
      de_d_ff <= i_de;
      if (i_frame_start) begin
        vfrac_ff <= '0;
        vy_ff <= '0;
        vlevel_ff <= 8'h00;
      end else if (de_d_ff && !i_de) begin
        vfrac_ff <= v_lvl_nx[FW-1:0];
        vy_ff <= vy_ff + FW'(1);
        vlevel_ff <= vlevel_ff + {7'h00, v_lvl_nx[FW]};
      end
    end
  end

  tpsc_color_map u_color_map (
    .i_code(eff_code),
    .i_invert(cfg_ff[tpsc_pkg::INV_BIT]),
    .i_hlevel(hlevel_ff),
    .i_vlevel(vlevel_ff),
    .i_custom(custom_ff),
    .o_rgb(fixed_rgb)
  );

  // Bars, four bands and the compliance checkerboard.
  always_comb begin
    case (hbar_ff)
      3'h0: bar_rgb = tpsc_pkg::RGB_WHITE;
      3'h1: bar_rgb = tpsc_pkg::RGB_YELLOW;
      3'h2: bar_rgb = tpsc_pkg::RGB_CYAN;
      3'h3: bar_rgb = tpsc_pkg::RGB_GREEN;
      3'h4: bar_rgb = tpsc_pkg::RGB_MAGENTA;
      3'h5: bar_rgb = tpsc_pkg::RGB_RED;
      3'h6: bar_rgb = tpsc_pkg::RGB_BLUE;
      default: bar_rgb = tpsc_pkg::RGB_BLACK;
    endcase
    case ({vy_ff >= V_HALF, hx_ff >= H_HALF})
      2'b00: band_rgb = ctl_ff[tpsc_pkg::REV_BIT] ?
                        tpsc_pkg::RGB_BLUE : tpsc_pkg::RGB_YELLOW;
      2'b01: band_rgb = tpsc_pkg::RGB_CYAN;
      2'b10: band_rgb = ctl_ff[tpsc_pkg::REV_BIT] ?
                        tpsc_pkg::RGB_YELLOW : tpsc_pkg::RGB_BLUE;
      default: band_rgb = tpsc_pkg::RGB_RED;
    endcase
    compl_rgb = (hx_ff[0] ^ vy_ff[0]) ? tpsc_pkg::RGB_WHITE :
                                        tpsc_pkg::RGB_BLACK;
    case (src_ff)
      tpsc_pkg::SRC_COMPL: nxt_pix = compl_rgb;
      tpsc_pkg::SRC_BARS: nxt_pix = bar_rgb;
      tpsc_pkg::SRC_BAND: nxt_pix = band_rgb;
      tpsc_pkg::SRC_FIXED: nxt_pix = fixed_rgb;
      default: nxt_pix = tpsc_pkg::RGB_BLACK;
    endcase
  end

  // Output pixel; black and not valid while the generator is off.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pix_ff <= tpsc_pkg::RGB_BLACK;
      valid_ff <= 1'b0;
    end else begin
      pix_ff <= (i_de && src_ff != tpsc_pkg::SRC_OFF) ? nxt_pix :
                tpsc_pkg::RGB_BLACK;
      valid_ff <= i_de && src_ff != tpsc_pkg::SRC_OFF;
    end
  end

  assign o_pix = pix_ff;
  assign o_pix_valid = valid_ff;
  assign o_rdata = rdata_ff;
  assign o_gen_active = (src_ff != tpsc_pkg::SRC_OFF);
  assign o_loop_pwdn = loop_ff[tpsc_pkg::LOOP_PWDN_BIT];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  chk_ctl_reset_val: assert property ($rose(i_rstn) |-> ctl_ff == 8'h10)
    else $error("Control register reset value wrong.");
  chk_gen_off_quiet: assert property (!ctl_ff[0] |=> ##1 !o_pix_valid)
    else $error("Pixel valid while generator disabled.");
  chk_compl_first: assert property (ctl_ff[0] && ctl_ff[3]
    |=> src_ff == tpsc_pkg::SRC_COMPL)
    else $error("Compliance pattern not given priority.");
  chk_bars_over_sel: assert property (ctl_ff[0] && !ctl_ff[3] && ctl_ff[2]
    |=> src_ff == tpsc_pkg::SRC_BARS)
    else $error("Colour bars not chosen over selector.");
  chk_bar_first_white: assert property (src_ff == tpsc_pkg::SRC_BARS &&
    i_de && hbar_ff == 3'h0 |=> o_pix == tpsc_pkg::RGB_WHITE)
    else $error("First colour bar is not white.");
  chk_scroll_ignores: assert property (cfg_ff[0] && $past(cfg_ff[0]) &&
    $stable(scroll_code_ff) |-> $stable(eff_code))
    else $error("Selector used while auto-scroll on.");
  chk_scroll_range: assert property (scroll_code_ff >= 4'h1 &&
    scroll_code_ff <= 4'hE)
    else $error("Scroll code outside valid patterns.");
  chk_solid_white: assert property (src_ff == tpsc_pkg::SRC_FIXED && i_de &&
    eff_code == 4'h1 && !cfg_ff[1] |=> o_pix == tpsc_pkg::RGB_WHITE)
    else $error("Code one did not give white.");
  chk_custom_inv: assert property (src_ff == tpsc_pkg::SRC_FIXED && i_de &&
    eff_code == 4'hE && cfg_ff[1] |=> o_pix == ~$past(custom_ff))
    else $error("Inverted custom colour wrong.");
  chk_band_top_left: assert property (src_ff == tpsc_pkg::SRC_BAND && i_de &&
    hx_ff == '0 && vy_ff == '0 |=> o_pix == ($past(ctl_ff[1]) ?
    tpsc_pkg::RGB_BLUE : tpsc_pkg::RGB_YELLOW))
    else $error("Four-band top-left colour wrong.");
  chk_ramp_black: assert property (src_ff == tpsc_pkg::SRC_FIXED && i_de &&
    eff_code == 4'h6 && !cfg_ff[1] && hlevel_ff == 8'h00 |=> o_pix == '0)
    else $error("Ramp does not start at black.");
  cov_bars_shown: cover property (src_ff == tpsc_pkg::SRC_BARS && i_de);
  cov_scroll_step: cover property (cfg_ff[0] ##1 $changed(scroll_code_ff));
  cov_custom_inv: cover property (eff_code == 4'hE && cfg_ff[1] && i_de);

endmodule : tpsc_top
`default_nettype wire

/* File: design/tpsc_pkg.sv */
// Purpose: Shared constants and types for the test pattern select control.
// Assumes: 8-bit register port, one pixel clock, 24-bit colour output.
// Notes: Offsets are byte addresses on the register port.
package tpsc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] ADDR_LOOP_CTL = 8'h63;
  localparam logic [7:0] ADDR_CONTROL = 8'h64;
  localparam logic [7:0] ADDR_CONFIG = 8'h65;
  localparam logic [7:0] ADDR_CUST_R = 8'h69;
  localparam logic [7:0] ADDR_CUST_G = 8'h6A;
  localparam logic [7:0] ADDR_CUST_B = 8'h6B;
  localparam logic [7:0] ADDR_FRAME_TIME = 8'h6C;
  localparam logic [7:0] ADDR_AUX = 8'h6D;
  localparam logic [7:0] ADDR_STATUS = 8'h6E;

  // Reset values.
  localparam logic [7:0] CONTROL_RST = 8'h10;
  localparam logic [7:0] FRAME_TIME_RST = 8'h01;
  localparam logic [7:0] ZERO_RST = 8'h00;

  // Field positions.
  localparam int unsigned SEL_MSB = 7;
  localparam int unsigned SEL_LSB = 4;
  localparam int unsigned COMPL_BIT = 3;
  localparam int unsigned BARS_BIT = 2;
  localparam int unsigned REV_BIT = 1;
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned INV_BIT = 1;
  localparam int unsigned ASCRL_BIT = 0;
  localparam int unsigned LOOP_PWDN_BIT = 0;
  localparam int unsigned FOUR_BAND_BIT = 0;

  // Fixed-pattern selector codes.
  localparam logic [3:0] SEL_WHITE = 4'h1;
  localparam logic [3:0] SEL_BLACK = 4'h2;
  localparam logic [3:0] SEL_RED = 4'h3;
  localparam logic [3:0] SEL_GREEN = 4'h4;
  localparam logic [3:0] SEL_BLUE = 4'h5;
  localparam logic [3:0] SEL_HRAMP = 4'h6;
  localparam logic [3:0] SEL_VRAMP = 4'hA;
  localparam logic [3:0] SEL_CUSTOM = 4'hE;
  localparam logic [3:0] SEL_FIRST = 4'h1;
  localparam logic [3:0] SEL_LAST = 4'hE;

  // Ramp levels and colour bar count.
  localparam int unsigned LEVELS = 256;
  localparam int unsigned BARS = 8;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } tpsc_rgb_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tpsc_bus_req_t;

  localparam tpsc_rgb_t RGB_BLACK = 24'h000000;
  localparam tpsc_rgb_t RGB_WHITE = 24'hFFFFFF;
  localparam tpsc_rgb_t RGB_RED = 24'hFF0000;
  localparam tpsc_rgb_t RGB_GREEN = 24'h00FF00;
  localparam tpsc_rgb_t RGB_BLUE = 24'h0000FF;
  localparam tpsc_rgb_t RGB_CYAN = 24'h00FFFF;
  localparam tpsc_rgb_t RGB_MAGENTA = 24'hFF00FF;
  localparam tpsc_rgb_t RGB_YELLOW = 24'hFFFF00;

  // Pattern source, one-hot.
  typedef enum logic [4:0] {
    SRC_OFF = 5'h01,
    SRC_COMPL = 5'h02,
    SRC_BARS = 5'h04,
    SRC_BAND = 5'h08,
    SRC_FIXED = 5'h10
  } tpsc_src_t;

endpackage : tpsc_pkg

/* File: design/tpsc_color_map.sv */
// Purpose: Maps a fixed-pattern code and ramp levels to a pixel colour.
// Assumes: Levels are already spread across the active region.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module tpsc_color_map (
  // Selection
  input wire logic [3:0] i_code,
  input wire logic i_invert,
  // Ramp levels and custom colour
  input wire logic [7:0] i_hlevel,
  input wire logic [7:0] i_vlevel,
  input wire tpsc_pkg::tpsc_rgb_t i_custom,
  // Result
  output tpsc_pkg::tpsc_rgb_t o_rgb
);

  tpsc_pkg::tpsc_rgb_t base;
  logic [1:0] hue;
  logic [7:0] lvl;

  always_comb begin
    hue = 2'(i_code - tpsc_pkg::SEL_HRAMP);
    lvl = (i_code >= tpsc_pkg::SEL_VRAMP) ? i_vlevel : i_hlevel;
    base = tpsc_pkg::RGB_BLACK;
    case (i_code)
      tpsc_pkg::SEL_WHITE: base = tpsc_pkg::RGB_WHITE;
      tpsc_pkg::SEL_BLACK: base = tpsc_pkg::RGB_BLACK;
      tpsc_pkg::SEL_RED: base = tpsc_pkg::RGB_RED;
      tpsc_pkg::SEL_GREEN: base = tpsc_pkg::RGB_GREEN;
      tpsc_pkg::SEL_BLUE: base = tpsc_pkg::RGB_BLUE;
      tpsc_pkg::SEL_CUSTOM: base = i_custom;
      4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD: begin
        // Hue order per group: white, red, green, blue.
        base.r = (hue == 2'h0 || hue == 2'h1) ? lvl : 8'h00;
        base.g = (hue == 2'h0 || hue == 2'h2) ? lvl : 8'h00;
        base.b = (hue == 2'h0 || hue == 2'h3) ? lvl : 8'h00;
      end
      default: base = tpsc_pkg::RGB_BLACK;
    endcase
    // Reserved codes stay black even when inverted.
    if (i_invert && i_code >= tpsc_pkg::SEL_FIRST &&
        i_code <= tpsc_pkg::SEL_LAST) begin
      o_rgb = ~base;
    end else begin
      o_rgb = base;
    end
  end

endmodule : tpsc_color_map
`default_nettype wire

/* File: testbench/tpsc_tb.sv */
// Purpose: Self-checking bench for the test pattern select control.
// Assumes: H_ACTIVE and V_ACTIVE are 256, so a ramp level equals position.
// Notes: Four-band checks see only the top lines, which keeps the run short.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int unsigned HA = 256;
  localparam int unsigned VA = 256;
  localparam logic [7:0] CORNER [5] = '{8'h1D, 8'h15, 8'h17, 8'h11, 8'h13};

  logic i_clk = 1'h0;
  logic i_rstn = 1'h0;
  tpsc_pkg::tpsc_bus_req_t i_bus = '0;
  logic i_de = 1'h0;
  logic i_frame_start = 1'h0;
  logic [7:0] o_rdata;
  tpsc_pkg::tpsc_rgb_t o_pix;
  logic o_pix_valid;
  logic o_gen_active;
  logic o_loop_pwdn;
  int n_mismatch = 0;
  int checked = 0;
  int seed = 70;
  logic [7:0] ctl = 8'h10;
  logic [7:0] cfg = 8'h00;
  logic [7:0] aux = 8'h00;
  tpsc_pkg::tpsc_rgb_t cust = '0;
  logic pend_chk = 1'h0;
  logic pend_v = 1'h0;
  tpsc_pkg::tpsc_rgb_t pend_pix = '0;

  always #10 i_clk = ~i_clk;

  tpsc_top #(.H_ACTIVE(HA), .V_ACTIVE(VA)) dut (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_bus(i_bus),
    .o_rdata(o_rdata),
    .i_de(i_de),
    .i_frame_start(i_frame_start),
    .o_pix(o_pix),
    .o_pix_valid(o_pix_valid),
    .o_gen_active(o_gen_active),
    .o_loop_pwdn(o_loop_pwdn)
  );

  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // The shadow copies feed the pixel model, so they follow every control, config, aux and custom colour write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_bus <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge i_clk);
    i_bus <= '0;
    case (a)
      tpsc_pkg::ADDR_CONTROL: ctl = d;
      tpsc_pkg::ADDR_CONFIG: cfg = d;
      tpsc_pkg::ADDR_AUX: aux = d;
      tpsc_pkg::ADDR_CUST_R: cust.r = d;
      tpsc_pkg::ADDR_CUST_G: cust.g = d;
      tpsc_pkg::ADDR_CUST_B: cust.b = d;
      default: ;
    endcase
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    i_bus <= '0;
    @(negedge i_clk);
    chk({16'h0000, o_rdata}, {16'h0000, e}, "read data");
  endtask : rd_chk

  function automatic tpsc_pkg::tpsc_rgb_t exp_pix(input int x, input int y);
    tpsc_pkg::tpsc_rgb_t p;
    logic [3:0] code;
    logic [7:0] lv;
    logic left;
    int hue;
    code = ctl[7:4];
    hue = (int'(code) - 6) % 4;
    lv = (code < 4'hA) ? 8'((x * 256) / HA) : 8'((y * 256) / VA);
    left = (x < HA / 2);
    p = tpsc_pkg::RGB_BLACK;
    if (ctl[0] !== 1'h1) return p;
    if (ctl[3]) begin
      p = (x[0] ^ y[0]) ? tpsc_pkg::RGB_WHITE : tpsc_pkg::RGB_BLACK;
    end else if (ctl[2]) begin
      case ((x * 8) / HA)
        0: p = tpsc_pkg::RGB_WHITE;
        1: p = tpsc_pkg::RGB_YELLOW;
        2: p = tpsc_pkg::RGB_CYAN;
        3: p = tpsc_pkg::RGB_GREEN;
        4: p = tpsc_pkg::RGB_MAGENTA;
        5: p = tpsc_pkg::RGB_RED;
        6: p = tpsc_pkg::RGB_BLUE;
        default: p = tpsc_pkg::RGB_BLACK;
      endcase
    end else if (aux[0]) begin
      if (y < VA / 2) begin
        p = !left ? tpsc_pkg::RGB_CYAN :
            ctl[1] ? tpsc_pkg::RGB_BLUE : tpsc_pkg::RGB_YELLOW;
      end else begin
        p = !left ? tpsc_pkg::RGB_RED :
            ctl[1] ? tpsc_pkg::RGB_YELLOW : tpsc_pkg::RGB_BLUE;
      end
    end else begin
      case (code)
        4'h1: p = tpsc_pkg::RGB_WHITE;
        4'h2: p = tpsc_pkg::RGB_BLACK;
        4'h3: p = tpsc_pkg::RGB_RED;
        4'h4: p = tpsc_pkg::RGB_GREEN;
        4'h5: p = tpsc_pkg::RGB_BLUE;
        4'hE: p = cust;
        4'h0, 4'hF: return tpsc_pkg::RGB_BLACK;
        default: p = {(hue < 2) ? lv : 8'h00,
                      (hue == 0 || hue == 2) ? lv : 8'h00,
                      (hue == 0 || hue == 3) ? lv : 8'h00};
      endcase
      if (cfg[1]) p = ~p;
    end
    return p;
  endfunction : exp_pix

  // Outputs lag the drive by one edge, so each step checks the step before.
  task automatic step(input logic de, input logic fs, input int x,
                      input int y);
    @(posedge i_clk);
    i_de <= de;
    i_frame_start <= fs;
    @(negedge i_clk);
    if (pend_chk) begin
      chk({23'h0, o_pix_valid}, {23'h0, pend_v}, "valid");
      chk(o_pix, pend_pix, "pixel");
    end
    pend_chk = 1'h1;
    pend_v = de & ctl[0];
    pend_pix = de ? exp_pix(x, y) : tpsc_pkg::RGB_BLACK;
  endtask : step

  task automatic frame(input int nl, input string name);
    pend_chk = 1'h0;
    step(1'h0, 1'h1, 0, 0);
    for (int y = 0; y < nl; y++) begin
      for (int x = 0; x < HA; x++) step(1'h1, 1'h0, x, y);
      for (int g = 0; g < 4; g++) step(1'h0, 1'h0, 0, 0);
    end
    $display("test %s done", name);
  endtask : frame

  task automatic results;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    #(20 * 60000);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'h1;
    @(negedge i_clk);
    chk({23'h0, o_gen_active}, 24'h000000, "gen after reset");
    rd_chk(tpsc_pkg::ADDR_CONTROL, tpsc_pkg::CONTROL_RST);
    rd_chk(tpsc_pkg::ADDR_CONFIG, 8'h00);
    rd_chk(tpsc_pkg::ADDR_LOOP_CTL, 8'h00);
    rd_chk(tpsc_pkg::ADDR_FRAME_TIME, tpsc_pkg::FRAME_TIME_RST);
    rd_chk(8'h70, 8'h00);
    wr(tpsc_pkg::ADDR_CONFIG, 8'hFF);
    rd_chk(tpsc_pkg::ADDR_CONFIG, 8'h03);
    wr(tpsc_pkg::ADDR_AUX, 8'hFF);
    rd_chk(tpsc_pkg::ADDR_AUX, 8'h01);
    wr(tpsc_pkg::ADDR_AUX, 8'h00);
    wr(tpsc_pkg::ADDR_CONFIG, 8'h00);
    wr(tpsc_pkg::ADDR_LOOP_CTL, 8'h01);
    @(negedge i_clk);
    chk({23'h0, o_loop_pwdn}, 24'h000001, "loop powered down");
    frame(1, "disabled after reset");
    wr(tpsc_pkg::ADDR_CUST_R, 8'($random(seed)));
    wr(tpsc_pkg::ADDR_CUST_G, 8'($random(seed)));
    wr(tpsc_pkg::ADDR_CUST_B, 8'($random(seed)));
    for (int inv = 0; inv < 2; inv++) begin
      wr(tpsc_pkg::ADDR_CONFIG, 8'(inv * 2));
      for (int code = 0; code < 16; code++) begin
        wr(tpsc_pkg::ADDR_CONTROL, {4'(code), 4'h1});
        frame(2, "fixed pattern");
      end
    end
    chk({23'h0, o_gen_active}, 24'h000001, "gen on");
    wr(tpsc_pkg::ADDR_AUX, 8'h01);
    foreach (CORNER[i]) begin
      wr(tpsc_pkg::ADDR_CONTROL, CORNER[i]);
      frame(2, "priority corner");
    end
    for (int i = 0; i < 6; i++) begin
      wr(tpsc_pkg::ADDR_AUX, 8'($random(seed)) & 8'h01);
      wr(tpsc_pkg::ADDR_CONFIG, 8'($random(seed)) & 8'h02);
      wr(tpsc_pkg::ADDR_CONTROL, 8'($random(seed)));
      frame(2, "random setup");
    end
    wr(tpsc_pkg::ADDR_AUX, 8'h00);
    wr(tpsc_pkg::ADDR_FRAME_TIME, 8'h02);
    wr(tpsc_pkg::ADDR_CONTROL, 8'h31);
    wr(tpsc_pkg::ADDR_CONFIG, 8'h01);
    for (int i = 0; i < 15; i++) begin
      rd_chk(tpsc_pkg::ADDR_STATUS, 8'h10 | 8'((i % 14) + 1));
      wr(tpsc_pkg::ADDR_CONTROL, {4'($random(seed)), 4'h1});
      repeat (2) begin
        step(1'h0, 1'h1, 0, 0);
        step(1'h0, 1'h0, 0, 0);
      end
    end
    $display("test auto scroll done");
    wr(tpsc_pkg::ADDR_CONFIG, 8'h00);
    wr(tpsc_pkg::ADDR_CONTROL, 8'h10);
    frame(1, "disabled again");
    chk({23'h0, o_gen_active}, 24'h000000, "gen off");
    results();
  end
endmodule : testbench
`default_nettype wire
